// [msc_defs.svh]
// Purpose: Offsets, field positions, reset values for the id screen config bank
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Definitions only
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_ADDR_W 5
`define MSC_IDX_MATCH_17 5'h11
`define MSC_IDX_MATCH_18 5'h12
`define MSC_IDX_MATCH_19 5'h13
`define MSC_IDX_CTRL_A 5'h14
`define MSC_IDX_CTRL_B 5'h15
`define MSC_IDX_IF_CFG 5'h16

`define MSC_RST_MATCH 8'h00
`define MSC_RST_CTRL_A 8'h00
`define MSC_RST_CTRL_B 8'h00
`define MSC_RST_IF_CFG 8'h20
`define MSC_RST_BW_CODE 3'h4
`define MSC_RST_START_BITS 8'h01
`define MSC_RST_CMP_BYTES 3'h1

`define MSC_MASK_CTRL_A 8'h7f
`define MSC_MASK_CTRL_B 8'h0f
`define MSC_MASK_IF_CFG 8'h7f

`define MSC_F_START_MSB 6
`define MSC_B_SCREEN_EN 3
`define MSC_B_BYTE_ORG 2
`define MSC_F_SCAN_MSB 1
`define MSC_B_SIDEBAND 6
`define MSC_F_BW_MSB 5
`define MSC_F_BW_LSB 3
`define MSC_B_CONV 2
`define MSC_B_IFBUF 1
`define MSC_B_CERF 0
`define MSC_BW_MAX_CODE 3'h4

`endif

// [msc_pkg.sv]
// Purpose: Types shared by the id screen config bank
// Assumes: Nothing beyond the defs header
// Notes: Bus states are one-hot
package msc_pkg;
    typedef logic [7:0] msc_byte_t;
    typedef enum logic [1:0] {
        MSC_BUS_IDLE = 2'b01,
        MSC_BUS_DONE = 2'b10
    } msc_bus_e;
endpackage

// [msc_cfg_if.sv]
// Purpose: Carries stored config bytes to the decoder and decoded values back
// Assumes: One clock domain
// Notes: No storage in here
`timescale 1ns/1ps
interface msc_cfg_if;
    msc_pkg::msc_byte_t ctrl_a;
    msc_pkg::msc_byte_t ctrl_b;
    msc_pkg::msc_byte_t if_cfg;
    logic [7:0] start_bits;
    logic [2:0] compare_bytes;
    logic bw_valid;
    modport src (output ctrl_a, output ctrl_b, output if_cfg,
                 input start_bits, input compare_bytes, input bw_valid);
    modport dec (input ctrl_a, input ctrl_b, input if_cfg,
                 output start_bits, output compare_bytes, output bw_valid);
endinterface

// [msc_cfg_decode.sv]
// Purpose: Turns stored control fields into start distance and byte count
// Assumes: Inputs come from flops
// Notes: Purely combinational
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_cfg_decode (
    msc_cfg_if.dec cfg
);
    logic [1:0] scan_code;
    logic byte_org;

    assign scan_code = cfg.ctrl_b[`MSC_F_SCAN_MSB:0];
    assign byte_org = cfg.ctrl_b[`MSC_B_BYTE_ORG];

    assign cfg.start_bits = {1'b0, cfg.ctrl_a[`MSC_F_START_MSB:0]} + 8'h01;

    always_comb begin
        if (byte_org) begin
            cfg.compare_bytes = {1'b0, scan_code} + 3'h1;
        end else begin
            cfg.compare_bytes = (scan_code == 2'h0) ? 3'h1 : 3'h2;
        end
    end

    assign cfg.bw_valid = (cfg.if_cfg[`MSC_F_BW_MSB:`MSC_F_BW_LSB] <= `MSC_BW_MAX_CODE);
endmodule

// [msc_screen_config.sv]
// Purpose: Id screening and IF config register bank on Avalon-MM with waitrequest
// Assumes: Word addressing, one wait state per access, inputs synchronous to MCLK
// Notes: Writes take effect at the edge that sees waitrequest low
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_screen_config #(
    parameter int DATA_W = 32
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [`MSC_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [DATA_W/8-1:0] AVS_BYTEENABLE,
    output logic [DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic FRAME_SYNC_FOUND,
    input wire logic BIT_STROBE,
    output logic COMPARE_ACTIVE,
    output logic [7:0] COMPARE_START_BITS,
    output logic ID_SCREEN_ENABLE,
    output logic ID_BYTE_ORGANISATION,
    output logic [1:0] ID_SCAN_BYTE_COUNT,
    output logic [2:0] ID_COMPARE_BYTES,
    output logic [7:0] ID_MATCH_BYTE_17,
    output logic [7:0] ID_MATCH_BYTE_18,
    output logic [7:0] ID_MATCH_BYTE_19,
    output logic SIDEBAND_SELECT,
    output logic [2:0] BANDPASS_WIDTH_SELECT,
    output logic BANDPASS_WIDTH_VALID,
    output logic CONVERSION_SCHEME_SELECT,
    output logic INTERMEDIATE_BUFFER_ENABLE,
    output logic CERAMIC_FILTER_COUNT
);
    localparam int N_ID = 3;

    generate
        if (DATA_W < 16 || DATA_W > 64 || (DATA_W % 8) != 0) begin : g_bad_width
            $error("DATA_W must be a multiple of 8 between 16 and 64");
        end
    endgenerate

    msc_cfg_if cfg ();

    msc_pkg::msc_bus_e bus_st_ff;
    msc_pkg::msc_bus_e nxt_bus_st;
    logic waitreq_ff;
    logic nxt_waitreq;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    msc_pkg::msc_byte_t ctrl_a_ff;
    msc_pkg::msc_byte_t nxt_ctrl_a;
    msc_pkg::msc_byte_t ctrl_b_ff;
    msc_pkg::msc_byte_t nxt_ctrl_b;
    msc_pkg::msc_byte_t if_cfg_ff;
    msc_pkg::msc_byte_t nxt_if_cfg;
    msc_pkg::msc_byte_t match_ff [N_ID];
    msc_pkg::msc_byte_t nxt_match [N_ID];
    logic [7:0] bit_cnt_ff;
    logic [7:0] nxt_bit_cnt;
    logic counting_ff;
    logic nxt_counting;
    logic nxt_active;
    logic req;
    logic wr_fire;
    logic rd_fire;
    logic wr_lane0;
    logic [7:0] start_m1;
    msc_pkg::msc_byte_t rd_byte;

    assign req = AVS_READ | AVS_WRITE;
    assign wr_fire = (bus_st_ff == msc_pkg::MSC_BUS_DONE) && AVS_WRITE;
    assign rd_fire = (bus_st_ff == msc_pkg::MSC_BUS_DONE) && AVS_READ;
    assign wr_lane0 = wr_fire && AVS_BYTEENABLE[0];
    assign start_m1 = {1'b0, ctrl_a_ff[`MSC_F_START_MSB:0]};

    assign cfg.ctrl_a = ctrl_a_ff;
    assign cfg.ctrl_b = ctrl_b_ff;
    assign cfg.if_cfg = if_cfg_ff;

    msc_cfg_decode u_decode (
        .cfg(cfg)
    );

    // Read mux; unmapped indices read zero
    always_comb begin
        rd_byte = 8'h00;
        case (AVS_ADDRESS)
            `MSC_IDX_MATCH_17: rd_byte = match_ff[0];
            `MSC_IDX_MATCH_18: rd_byte = match_ff[1];
            `MSC_IDX_MATCH_19: rd_byte = match_ff[2];
            `MSC_IDX_CTRL_A: rd_byte = ctrl_a_ff;
            `MSC_IDX_CTRL_B: rd_byte = ctrl_b_ff;
            `MSC_IDX_IF_CFG: rd_byte = if_cfg_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    // Bus slave and control registers
    always_comb begin
        nxt_bus_st = bus_st_ff;
        nxt_waitreq = waitreq_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl_a = ctrl_a_ff;
        nxt_ctrl_b = ctrl_b_ff;
        nxt_if_cfg = if_cfg_ff;
        case (bus_st_ff)
            msc_pkg::MSC_BUS_IDLE: begin
                if (req) begin
                    nxt_bus_st = msc_pkg::MSC_BUS_DONE;
                    nxt_waitreq = 1'b0;
                    nxt_rdata = {{(DATA_W-8){1'b0}}, rd_byte};
                end
            end
            msc_pkg::MSC_BUS_DONE: begin
                // Back to idle even if the master dropped the request early
                nxt_bus_st = msc_pkg::MSC_BUS_IDLE;
                nxt_waitreq = 1'b1;
            end
            default: begin
                nxt_bus_st = msc_pkg::MSC_BUS_IDLE;
                nxt_waitreq = 1'b1;
            end
        endcase
        if (wr_lane0) begin
            case (AVS_ADDRESS)
                `MSC_IDX_CTRL_A: nxt_ctrl_a = AVS_WRITEDATA[7:0] & `MSC_MASK_CTRL_A;
                `MSC_IDX_CTRL_B: nxt_ctrl_b = AVS_WRITEDATA[7:0] & `MSC_MASK_CTRL_B;
                `MSC_IDX_IF_CFG: nxt_if_cfg = AVS_WRITEDATA[7:0] & `MSC_MASK_IF_CFG;
                default: nxt_ctrl_a = ctrl_a_ff;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bus_st_ff <= msc_pkg::MSC_BUS_IDLE;
            waitreq_ff <= 1'b1;
            rdata_ff <= '0;
            ctrl_a_ff <= `MSC_RST_CTRL_A;
            ctrl_b_ff <= `MSC_RST_CTRL_B;
            if_cfg_ff <= `MSC_RST_IF_CFG;
        end else begin
            bus_st_ff <= nxt_bus_st;
            waitreq_ff <= nxt_waitreq;
            rdata_ff <= nxt_rdata;
            ctrl_a_ff <= nxt_ctrl_a;
            ctrl_b_ff <= nxt_ctrl_b;
            if_cfg_ff <= nxt_if_cfg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_ID; gi++) begin : g_match
            always_comb begin
                nxt_match[gi] = match_ff[gi];
                if (wr_lane0 && AVS_ADDRESS == `MSC_ADDR_W'(`MSC_IDX_MATCH_17 + gi)) begin
                    nxt_match[gi] = AVS_WRITEDATA[7:0];
                end
            end
            always_ff @(posedge MCLK) begin
                if (SRST) begin
                    match_ff[gi] <= `MSC_RST_MATCH;
                end else begin
                    match_ff[gi] <= nxt_match[gi];
                end
            end
        end
    endgenerate

    // Bit distance after frame sync
    always_comb begin
        nxt_bit_cnt = bit_cnt_ff;
        nxt_counting = counting_ff;
        nxt_active = COMPARE_ACTIVE;
        if (!ctrl_b_ff[`MSC_B_SCREEN_EN]) begin
            nxt_counting = 1'b0;
            nxt_active = 1'b0;
            nxt_bit_cnt = 8'h00;
        end else if (FRAME_SYNC_FOUND) begin
            // A fresh sync restarts the distance, even mid-compare
            nxt_counting = 1'b1;
            nxt_active = 1'b0;
            nxt_bit_cnt = 8'h00;
        end else if (counting_ff && BIT_STROBE) begin
            nxt_bit_cnt = bit_cnt_ff + 8'h01;
            if (bit_cnt_ff + 8'h01 == cfg.start_bits) begin
                nxt_active = 1'b1;
                nxt_counting = 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bit_cnt_ff <= 8'h00;
            counting_ff <= 1'b0;
            COMPARE_ACTIVE <= 1'b0;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            counting_ff <= nxt_counting;
            COMPARE_ACTIVE <= nxt_active;
        end
    end

    // Registered outputs; one cycle behind the stored bytes
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            AVS_READDATA <= '0;
            AVS_WAITREQUEST <= 1'b1;
            COMPARE_START_BITS <= `MSC_RST_START_BITS;
            ID_SCREEN_ENABLE <= 1'b0;
            ID_BYTE_ORGANISATION <= 1'b0;
            ID_SCAN_BYTE_COUNT <= 2'h0;
            ID_COMPARE_BYTES <= `MSC_RST_CMP_BYTES;
            ID_MATCH_BYTE_17 <= `MSC_RST_MATCH;
            ID_MATCH_BYTE_18 <= `MSC_RST_MATCH;
            ID_MATCH_BYTE_19 <= `MSC_RST_MATCH;
            SIDEBAND_SELECT <= 1'b0;
            BANDPASS_WIDTH_SELECT <= `MSC_RST_BW_CODE;
            BANDPASS_WIDTH_VALID <= 1'b1;
            CONVERSION_SCHEME_SELECT <= 1'b0;
            INTERMEDIATE_BUFFER_ENABLE <= 1'b0;
            CERAMIC_FILTER_COUNT <= 1'b0;
        end else begin
            AVS_READDATA <= nxt_rdata;
            AVS_WAITREQUEST <= nxt_waitreq;
            COMPARE_START_BITS <= cfg.start_bits;
            ID_SCREEN_ENABLE <= ctrl_b_ff[`MSC_B_SCREEN_EN];
            ID_BYTE_ORGANISATION <= ctrl_b_ff[`MSC_B_BYTE_ORG];
            ID_SCAN_BYTE_COUNT <= ctrl_b_ff[`MSC_F_SCAN_MSB:0];
            ID_COMPARE_BYTES <= cfg.compare_bytes;
            ID_MATCH_BYTE_17 <= match_ff[0];
            ID_MATCH_BYTE_18 <= match_ff[1];
            ID_MATCH_BYTE_19 <= match_ff[2];
            SIDEBAND_SELECT <= if_cfg_ff[`MSC_B_SIDEBAND];
            BANDPASS_WIDTH_SELECT <= if_cfg_ff[`MSC_F_BW_MSB:`MSC_F_BW_LSB];
            BANDPASS_WIDTH_VALID <= cfg.bw_valid;
            CONVERSION_SCHEME_SELECT <= if_cfg_ff[`MSC_B_CONV];
            INTERMEDIATE_BUFFER_ENABLE <= if_cfg_ff[`MSC_B_IFBUF];
            CERAMIC_FILTER_COUNT <= if_cfg_ff[`MSC_B_CERF];
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence s_wr_to(logic [`MSC_ADDR_W-1:0] idx);
        wr_lane0 && AVS_ADDRESS == idx;
    endsequence

    sequence s_rd_of(logic [`MSC_ADDR_W-1:0] idx);
        rd_fire && AVS_ADDRESS == idx;
    endsequence

    property p_start_distance;
        $rose(COMPARE_ACTIVE) |-> $past(bit_cnt_ff) == $past(start_m1);
    endproperty
    a_start_distance: assert property (p_start_distance) else $error("compare opened at wrong bit");

    property p_disabled_idle;
        !ctrl_b_ff[`MSC_B_SCREEN_EN] |=> !COMPARE_ACTIVE && !counting_ff;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("screening active while disabled");

    property p_org_follows_write;
        s_wr_to(`MSC_IDX_CTRL_B) |-> ##2 ID_BYTE_ORGANISATION == $past(AVS_WRITEDATA[`MSC_B_BYTE_ORG], 2);
    endproperty
    a_org_follows_write: assert property (p_org_follows_write) else $error("byte organisation not updated");

    property p_four_byte_count;
        ID_BYTE_ORGANISATION |-> ID_COMPARE_BYTES == {1'b0, ID_SCAN_BYTE_COUNT} + 3'h1;
    endproperty
    a_four_byte_count: assert property (p_four_byte_count) else $error("bad byte count in four byte mode");

    property p_two_byte_count;
        !ID_BYTE_ORGANISATION |-> ID_COMPARE_BYTES == ((ID_SCAN_BYTE_COUNT == 2'h0) ? 3'h1 : 3'h2);
    endproperty
    a_two_byte_count: assert property (p_two_byte_count) else $error("bad byte count in two byte mode");

    property p_match_write;
        s_wr_to(`MSC_IDX_MATCH_18) |-> ##2 ID_MATCH_BYTE_18 == $past(AVS_WRITEDATA[7:0], 2);
    endproperty
    a_match_write: assert property (p_match_write) else $error("id byte not stored");

    property p_bw_valid;
        BANDPASS_WIDTH_VALID == (BANDPASS_WIDTH_SELECT <= `MSC_BW_MAX_CODE);
    endproperty
    a_bw_valid: assert property (p_bw_valid) else $error("bandwidth valid flag wrong");

    property p_if_bits_write;
        s_wr_to(`MSC_IDX_IF_CFG) |-> ##2
            {SIDEBAND_SELECT, CONVERSION_SCHEME_SELECT, INTERMEDIATE_BUFFER_ENABLE, CERAMIC_FILTER_COUNT}
            == {$past(AVS_WRITEDATA[`MSC_B_SIDEBAND], 2), $past(AVS_WRITEDATA[2:0], 2)};
    endproperty
    a_if_bits_write: assert property (p_if_bits_write) else $error("IF bits not updated");

    property p_unused_zero;
        s_rd_of(`MSC_IDX_CTRL_B) |-> AVS_READDATA[DATA_W-1:4] == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

    property p_one_wait;
        (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest timing wrong");
endmodule

// [message_id_screen_config_tb.sv]
// Purpose: Self-checking bench for the id screen config bank
// Assumes: One wait state per access, outputs lag stores by one edge
// Notes: Bus answer sampled at the rising edge where it stands
`timescale 1ns/1ps
`include "msc_defs.svh"
module message_id_screen_config_tb;
    logic mclk;
    logic srst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic frame_sync;
    logic bit_strobe;
    logic cmp_act;
    logic [7:0] start_bits;
    logic scr_en;
    logic byte_org;
    logic [1:0] scan_cnt;
    logic [2:0] cmp_bytes;
    logic [7:0] mb17;
    logic [7:0] mb18;
    logic [7:0] mb19;
    logic sideband;
    logic [2:0] bw_sel;
    logic bw_ok;
    logic conv;
    logic ifbuf;
    logic cerf;
    int miscompares;
    int cmp_count;
    int cycles;
    logic [31:0] rdv;

    msc_screen_config #(.DATA_W(32)) i_dut (
        .MCLK(mclk), .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .FRAME_SYNC_FOUND(frame_sync), .BIT_STROBE(bit_strobe), .COMPARE_ACTIVE(cmp_act),
        .COMPARE_START_BITS(start_bits), .ID_SCREEN_ENABLE(scr_en), .ID_BYTE_ORGANISATION(byte_org),
        .ID_SCAN_BYTE_COUNT(scan_cnt), .ID_COMPARE_BYTES(cmp_bytes), .ID_MATCH_BYTE_17(mb17),
        .ID_MATCH_BYTE_18(mb18), .ID_MATCH_BYTE_19(mb19), .SIDEBAND_SELECT(sideband),
        .BANDPASS_WIDTH_SELECT(bw_sel), .BANDPASS_WIDTH_VALID(bw_ok),
        .CONVERSION_SCHEME_SELECT(conv), .INTERMEDIATE_BUFFER_ENABLE(ifbuf),
        .CERAMIC_FILTER_COUNT(cerf)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, whole run needs about 400 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 8000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at an edge; released at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // No wait limit here; the hang guard ends a stuck access
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rdv, exp);
    endtask

    // Outputs follow a store one edge later
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic strobes(input int n);
        repeat (n) begin
            @(posedge mclk);
            bit_strobe <= 1'b1;
        end
        @(posedge mclk);
        bit_strobe <= 1'b0;
    endtask

    task automatic sync();
        @(posedge mclk);
        frame_sync <= 1'b1;
        @(posedge mclk);
        frame_sync <= 1'b0;
    endtask

    initial begin
        int offs[4];
        offs = '{0, 1, 5, 127};
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        frame_sync = 1'b0;
        bit_strobe = 1'b0;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        settle();
        chk({start_bits, 5'h0, cmp_bytes, 5'h0, bw_sel, 7'h0, bw_ok}, 32'h0101_0401);
        chk({scr_en, byte_org, scan_cnt, sideband, conv, ifbuf, cerf, cmp_act}, 32'h0);
        rdc(`MSC_IDX_MATCH_17, 32'h00);
        rdc(`MSC_IDX_MATCH_18, 32'h00);
        rdc(`MSC_IDX_MATCH_19, 32'h00);
        rdc(`MSC_IDX_CTRL_A, 32'h00);
        rdc(`MSC_IDX_CTRL_B, 32'h00);
        rdc(`MSC_IDX_IF_CFG, 32'h20);
        $display("test reset values done");

        wr(`MSC_IDX_MATCH_17, 32'hffff_ff11);
        wr(`MSC_IDX_MATCH_18, 32'h0000_00a5);
        wr(`MSC_IDX_MATCH_19, 32'h0000_00ff);
        // Disabled byte lane must not store
        bus(1'b1, `MSC_IDX_MATCH_18, 32'h0000_0033, 4'he);
        wr(5'h00, 32'h0000_00ff);
        settle();
        chk({mb17, mb18, mb19}, 32'h11a5ff);
        rdc(`MSC_IDX_MATCH_17, 32'h11);
        rdc(`MSC_IDX_MATCH_18, 32'ha5);
        rdc(5'h00, 32'h0);
        rdc(5'h1f, 32'h0);
        $display("test id bytes done");

        // Unused bits dropped on write
        wr(`MSC_IDX_CTRL_A, 32'hffff_ffff);
        wr(`MSC_IDX_CTRL_B, 32'hffff_fff0);
        wr(`MSC_IDX_IF_CFG, 32'hffff_ffff);
        rdc(`MSC_IDX_CTRL_A, 32'h7f);
        rdc(`MSC_IDX_CTRL_B, 32'h00);
        rdc(`MSC_IDX_IF_CFG, 32'h7f);
        settle();
        chk({24'h0, start_bits}, 32'h80);
        $display("test unused bits done");

        for (int k = 0; k < 8; k++) begin
            wr(`MSC_IDX_IF_CFG, {25'h0, k[0], k[2:0], k[2:0]});
            settle();
            chk({sideband, bw_sel, bw_ok}, {k[0], k[2:0], (k <= 4)});
            chk({conv, ifbuf, cerf}, k[2:0]);
        end
        $display("test if config done");

        for (int org = 0; org < 2; org++) begin
            for (int c = 0; c < 4; c++) begin
                wr(`MSC_IDX_CTRL_B, (org << 2) | c);
                settle();
                chk({byte_org, scan_cnt}, (org << 2) | c);
                chk(cmp_bytes, (org == 1) ? c + 1 : ((c == 0) ? 1 : 2));
            end
        end
        $display("test scan count done");

        foreach (offs[i]) begin
            wr(`MSC_IDX_CTRL_A, offs[i]);
            wr(`MSC_IDX_CTRL_B, 32'h08);
            settle();
            chk({scr_en, start_bits}, 9'h100 + offs[i] + 1);
            sync();
            strobes(offs[i]);
            settle();
            chk(cmp_act, 1'b0);
            strobes(1);
            settle();
            chk(cmp_act, 1'b1);
        end
        wr(`MSC_IDX_CTRL_B, 32'h00);
        settle();
        chk(cmp_act, 1'b0);
        wr(`MSC_IDX_CTRL_A, 32'h00);
        settle();
        sync();
        strobes(3);
        settle();
        chk({scr_en, cmp_act}, 2'b00);
        $display("test start offset done");

        // Mid-run reset must clear what was written
        wr(`MSC_IDX_MATCH_19, 32'h0000_005a);
        wr(`MSC_IDX_CTRL_B, 32'h0000_0007);
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        settle();
        chk({mb19, byte_org, cmp_bytes}, 32'h001);
        rdc(`MSC_IDX_MATCH_19, 32'h00);
        rdc(`MSC_IDX_CTRL_B, 32'h00);
        rdc(`MSC_IDX_IF_CFG, 32'h20);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
